// File: verilog/mdr_defs.vh
// constants for the metering data record readout
`ifndef MDR_DEFS_VH
`define MDR_DEFS_VH
`define MDR_WORD_W 32
`define MDR_DATA_W 28
`define MDR_NIB_W 4
`define MDR_NIBS 7
`define MDR_EN_W 20
`define MDR_ST_W 8
`define MDR_U_W 12
`define MDR_I_W 16
`define MDR_TP_ST_W 12
`define MDR_TSG_W 4
`define MDR_SYS_W 8
`define MDR_PHASES 3
`define MDR_CFG_W 112
`define MDR_FUND_BIT 42
`define MDR_FIFO_DEPTH 16
`define MDR_FIFO_AW 4
`define MDR_GRP_LAST 3'h6
`define MDR_REC_LAST 5'h1b
`define MDR_BIT_LAST 5'h1f
`define MDR_PIN_IDLE 3'h2
`define MDR_R_TP_ACT 5'h00
`define MDR_R_TP_REA 5'h01
`define MDR_R_TP_FUN 5'h02
`define MDR_R_PERIOD 5'h03
`define MDR_R_MOM_R 5'h04
`define MDR_R_MOM_S 5'h05
`define MDR_R_MOM_T 5'h06
`define MDR_R_MOM_N 5'h07
`define MDR_R_RMS_R 5'h08
`define MDR_R_RMS_S 5'h09
`define MDR_R_RMS_T 5'h0a
`define MDR_R_RMS_N 5'h0b
`define MDR_R_ACT_R 5'h0c
`define MDR_R_ACT_S 5'h0d
`define MDR_R_ACT_T 5'h0e
`define MDR_R_CFG0 5'h0f
`define MDR_R_REA_R 5'h10
`define MDR_R_REA_S 5'h11
`define MDR_R_REA_T 5'h12
`define MDR_R_CFG1 5'h13
`define MDR_R_FUN_R 5'h14
`define MDR_R_FUN_S 5'h15
`define MDR_R_FUN_T 5'h16
`define MDR_R_CFG2 5'h17
`define MDR_R_ACC_R 5'h18
`define MDR_R_ACC_S 5'h19
`define MDR_R_ACC_T 5'h1a
`define MDR_R_CFG3 5'h1b
`endif

// File: verilog/mdr_fifo.v
// record buffer between the record assembler and the serial shifter
`timescale 1ns/100ps
`default_nettype none
module mdr_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clock_i,
	input  wire             reset_n_i,
	input  wire             flush_i,
	// filling side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// draining side
	output reg              out_valid_o,
	input  wire             out_ready_i,
	output reg  [WIDTH-1:0] out_data_o
);
	localparam [AW:0] FULL = DEPTH;
	localparam [AW:0] ONE  = 1;
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr;
	reg  [AW-1:0]    rd_ptr;
	reg  [AW:0]      cnt;
	wire             push;
	wire             load;
	assign in_ready_o = (cnt != FULL);
	assign push = in_valid_i & in_ready_o & ~flush_i;
	// head moves into the output register when it is free or taken
	assign load = (~out_valid_o | out_ready_i) & (cnt != {(AW+1){1'b0}}) & ~flush_i;
	always @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr      <= {AW{1'b0}};
			rd_ptr      <= {AW{1'b0}};
			cnt         <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {WIDTH{1'b0}};
		end else if (flush_i) begin
			wr_ptr      <= {AW{1'b0}};
			rd_ptr      <= {AW{1'b0}};
			cnt         <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + ONE[AW-1:0];
			end
			if (load) begin
				rd_ptr      <= rd_ptr + ONE[AW-1:0];
				out_data_o  <= mem[rd_ptr];
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			if (push && !load) begin
				cnt <= cnt + ONE;
			end else if (load && !push) begin
				cnt <= cnt - ONE;
			end
		end
	end
endmodule // mdr_fifo
`default_nettype wire

// File: verilog/mdr_readout.v
// serial readout of the seven groups of four metering data records
// Notes on behaviour
// - seven groups of four records, each a parity nibble and 28 data bits
// - records come out in fixed order, no address; host picks how many
// - precharge before a frame advances the group pointer for the next read
// - record 0.1: three-phase active energy and status bits 0 to 7
// - record 0.3: three-phase fundamental energy and the eight system signals
// - record 0.4: period from R phase, else S phase, else T phase
// - record 0.4 also holds neutral DC: offset, or hall value when selected
// - records 1.1 to 1.3: momentary voltage and current of R, S, T
// - record 1.4: RMS of current sum over four and neutral momentary current
// - without neutral, line-to-line voltages ST, TR, RS replace phase voltages
// - records 2.1 to 2.3: RMS voltage and current of R, S, T
// - record 2.4: neutral voltage channel RMS by hall select, neutral RMS current
// - records 3.1 to 3.3: phase active energy and status, bit 0 no-load
// - fourth record of groups 3 to 6 carries the 112 configuration bits
// - records 4.1 to 4.3: phase reactive energy and status, reactive no-load
// - fundamental select bit swaps fundamental reactive into the phase reactive records 4.1 to 4.3
// - records 5.1 to 5.3: phase fundamental energy and status, its no-load
// - records 6.1 to 6.3: single wire current accumulator and phase delay
// - each parity bit is odd parity over seven matching data nibble bits, parity bits 0 to 2 also xor the group number
// - configuration read from shadow latches if source set, else from cells
`timescale 1ns/100ps
`default_nettype none
`include "mdr_defs.vh"
module mdr_readout #(
	parameter FIFO_DEPTH = `MDR_FIFO_DEPTH,
	parameter FIFO_AW    = `MDR_FIFO_AW
) (
	// clock and reset
	input  wire                       clock_i,
	input  wire                       reset_n_i,
	// serial pins from the host
	input  wire                       sclk_i,
	input  wire                       scs_n_i,
	input  wire                       precharge_i,
	output reg                        sdo_o,
	output reg                        sdo_oe_o,
	output reg  [2:0]                 group_pointer_o,
	// three-phase totals
	input  wire [`MDR_EN_W-1:0]       tp_active_i,
	input  wire [`MDR_EN_W-1:0]       tp_reactive_i,
	input  wire [`MDR_EN_W-1:0]       tp_fundamental_i,
	input  wire [`MDR_TP_ST_W-1:0]    tp_status_i,
	input  wire [`MDR_TSG_W-1:0]      test_mode_signals_i,
	// system signals
	input  wire                       bank_i,
	input  wire                       pump_i,
	input  wire                       test_signal_zero_i,
	input  wire                       test_signal_one_i,
	input  wire                       test_signal_two_i,
	input  wire                       config_source_i,
	input  wire                       write_enable_i,
	// period and neutral channel
	input  wire [`MDR_U_W*3-1:0]      period_i,
	input  wire [2:0]                 phase_present_i,
	input  wire [`MDR_I_W-1:0]        neutral_dc_offset_i,
	input  wire [`MDR_I_W-1:0]        hall_sensor_input_dc_i,
	input  wire                       neutral_channel_hall_select_i,
	input  wire                       no_neutral_mode_i,
	// momentary values
	input  wire [`MDR_U_W*3-1:0]      volt_mom_i,
	input  wire [`MDR_U_W*3-1:0]      line_volt_mom_i,
	input  wire [`MDR_I_W*3-1:0]      curr_mom_i,
	input  wire [`MDR_U_W-1:0]        sum_curr_rms_i,
	input  wire [`MDR_I_W-1:0]        neutral_curr_mom_i,
	// rms values
	input  wire [`MDR_U_W*3-1:0]      volt_rms_i,
	input  wire [`MDR_U_W*3-1:0]      line_volt_rms_i,
	input  wire [`MDR_I_W*3-1:0]      curr_rms_i,
	input  wire [`MDR_U_W-1:0]        neutral_voltage_input_rms_i,
	input  wire [`MDR_U_W-1:0]        hall_sensor_input_rms_i,
	input  wire [`MDR_I_W-1:0]        neutral_curr_rms_i,
	// per-phase energies, status and no-load flags
	input  wire [`MDR_EN_W*3-1:0]     phase_active_i,
	input  wire [`MDR_EN_W*3-1:0]     phase_reactive_i,
	input  wire [`MDR_EN_W*3-1:0]     phase_fund_reactive_i,
	input  wire [`MDR_EN_W*3-1:0]     phase_fundamental_i,
	input  wire [`MDR_ST_W*3-1:0]     phase_status_i,
	input  wire [2:0]                 active_no_load_flag_i,
	input  wire [2:0]                 reactive_no_load_flag_i,
	input  wire [2:0]                 fund_no_load_flag_i,
	// single wire meter mode accumulators and phase delay
	input  wire [`MDR_EN_W*3-1:0]     single_wire_meter_mode_acc_i,
	input  wire [`MDR_ST_W*3-1:0]     phase_delay_i,
	// configuration bits
	input  wire [`MDR_CFG_W-1:0]      config_shadow_i,
	input  wire [`MDR_CFG_W-1:0]      config_otp_i
);
	// ************************************************************
	// reset release and pin synchronisers
	// ************************************************************
	reg                    rst_s1;
	reg                    rst_n;
	reg  [2:0]             pin_s1;
	reg  [2:0]             pin_s2;
	reg  [2:0]             pin_s3;
	reg  [2:0]             pin_f;
	reg  [2:0]             pin_d;
	wire [2:0]             pin_raw;
	localparam [2:0]       PIN_IDLE = `MDR_PIN_IDLE;
	assign pin_raw  = {precharge_i, scs_n_i, sclk_i};
	// stages reset to idle levels so no false edge follows reset
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end
	genvar b;
	generate
		for (b = 0; b < 3; b = b + 1) begin : g_sync
			// a level counts only once the second and third stages agree
			always @(posedge clock_i or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1[b] <= PIN_IDLE[b];
					pin_s2[b] <= PIN_IDLE[b];
					pin_s3[b] <= PIN_IDLE[b];
					pin_f[b]  <= PIN_IDLE[b];
					pin_d[b]  <= PIN_IDLE[b];
				end else begin
					pin_s1[b] <= pin_raw[b];
					pin_s2[b] <= pin_s1[b];
					pin_s3[b] <= pin_s2[b];
					if (pin_s2[b] == pin_s3[b]) begin
						pin_f[b] <= pin_s3[b];
					end
					pin_d[b] <= pin_f[b];
				end
			end
		end
	endgenerate
	wire sclk_fall;
	wire cs_start;
	wire cs_end;
	wire pre_rise;
	assign sclk_fall = pin_d[0] & ~pin_f[0];
	assign cs_start  = pin_d[1] & ~pin_f[1];
	assign cs_end    = ~pin_d[1] & pin_f[1];
	assign pre_rise  = ~pin_d[2] & pin_f[2];
	// ************************************************************
	// per-phase record words
	// ************************************************************
	wire [`MDR_CFG_W-1:0]  cfg;
	wire                   fund_sel;
	wire [`MDR_DATA_W-1:0] mom_w [0:2];
	wire [`MDR_DATA_W-1:0] rms_w [0:2];
	wire [`MDR_DATA_W-1:0] act_w [0:2];
	wire [`MDR_DATA_W-1:0] rea_w [0:2];
	wire [`MDR_DATA_W-1:0] fun_w [0:2];
	wire [`MDR_DATA_W-1:0] acc_w [0:2];
	wire [`MDR_DATA_W-1:0] cfg_w [0:3];
	assign cfg      = config_source_i ? config_shadow_i : config_otp_i;
	assign fund_sel = cfg[`MDR_FUND_BIT];
	genvar p;
	generate
		for (p = 0; p < `MDR_PHASES; p = p + 1) begin : g_phase
			wire [`MDR_EN_W-1:0]   rea_src;
			wire [`MDR_ST_W-2:0]   st_hi;
			wire [`MDR_U_W-1:0]    u_mom;
			wire [`MDR_U_W-1:0]    u_rms;
			assign rea_src = fund_sel ? phase_fund_reactive_i[p*`MDR_EN_W +: `MDR_EN_W]
				: phase_reactive_i[p*`MDR_EN_W +: `MDR_EN_W];
			assign st_hi = phase_status_i[p*`MDR_ST_W+1 +: `MDR_ST_W-1];
			assign u_mom = no_neutral_mode_i ? line_volt_mom_i[p*`MDR_U_W +: `MDR_U_W]
				: volt_mom_i[p*`MDR_U_W +: `MDR_U_W];
			assign u_rms = no_neutral_mode_i ? line_volt_rms_i[p*`MDR_U_W +: `MDR_U_W]
				: volt_rms_i[p*`MDR_U_W +: `MDR_U_W];
			assign mom_w[p] = {u_mom, curr_mom_i[p*`MDR_I_W +: `MDR_I_W]};
			assign rms_w[p] = {u_rms, curr_rms_i[p*`MDR_I_W +: `MDR_I_W]};
			assign act_w[p] = {phase_active_i[p*`MDR_EN_W +: `MDR_EN_W], st_hi,
				active_no_load_flag_i[p]};
			assign rea_w[p] = {rea_src, st_hi, reactive_no_load_flag_i[p]};
			assign fun_w[p] = {phase_fundamental_i[p*`MDR_EN_W +: `MDR_EN_W], st_hi,
				fund_no_load_flag_i[p]};
			assign acc_w[p] = {single_wire_meter_mode_acc_i[p*`MDR_EN_W +: `MDR_EN_W],
				phase_delay_i[p*`MDR_ST_W +: `MDR_ST_W]};
		end
		for (p = 0; p < 4; p = p + 1) begin : g_cfg
			assign cfg_w[p] = cfg[p*`MDR_DATA_W +: `MDR_DATA_W];
		end
	endgenerate
	// ************************************************************
	// record selection and parity
	// ************************************************************
	reg  [4:0]              asm_idx;
	reg                     asm_run;
	reg  [`MDR_DATA_W-1:0]  next_rec;
	reg  [`MDR_NIB_W-1:0]   nib_x;
	wire [`MDR_NIB_W-1:0]   parity;
	wire [`MDR_U_W-1:0]     period_sel;
	wire [`MDR_I_W-1:0]     dc_sel;
	wire [`MDR_U_W-1:0]     un_rms_sel;
	wire [`MDR_SYS_W-1:0]   sys_bits;
	assign period_sel = phase_present_i[0] ? period_i[0 +: `MDR_U_W]
		: phase_present_i[1] ? period_i[`MDR_U_W +: `MDR_U_W]
		: period_i[2*`MDR_U_W +: `MDR_U_W];
	assign dc_sel = neutral_channel_hall_select_i ? hall_sensor_input_dc_i : neutral_dc_offset_i;
	assign un_rms_sel = neutral_channel_hall_select_i ? hall_sensor_input_rms_i
		: neutral_voltage_input_rms_i;
	assign sys_bits = {bank_i, pump_i, test_signal_zero_i, test_signal_one_i,
		test_signal_two_i, config_source_i, write_enable_i, pin_f[2]};
	always @* begin
		next_rec = {`MDR_DATA_W{1'b0}};
		case (asm_idx)
			`MDR_R_TP_ACT: next_rec = {tp_active_i, tp_status_i[`MDR_ST_W-1:0]};
			`MDR_R_TP_REA: next_rec = {tp_reactive_i,
				tp_status_i[`MDR_TP_ST_W-1:`MDR_ST_W], test_mode_signals_i};
			`MDR_R_TP_FUN: next_rec = {tp_fundamental_i, sys_bits};
			`MDR_R_PERIOD: next_rec = {period_sel, dc_sel};
			`MDR_R_MOM_R:  next_rec = mom_w[0];
			`MDR_R_MOM_S:  next_rec = mom_w[1];
			`MDR_R_MOM_T:  next_rec = mom_w[2];
			`MDR_R_MOM_N:  next_rec = {sum_curr_rms_i, neutral_curr_mom_i};
			`MDR_R_RMS_R:  next_rec = rms_w[0];
			`MDR_R_RMS_S:  next_rec = rms_w[1];
			`MDR_R_RMS_T:  next_rec = rms_w[2];
			`MDR_R_RMS_N:  next_rec = {un_rms_sel, neutral_curr_rms_i};
			`MDR_R_ACT_R:  next_rec = act_w[0];
			`MDR_R_ACT_S:  next_rec = act_w[1];
			`MDR_R_ACT_T:  next_rec = act_w[2];
			`MDR_R_CFG0:   next_rec = cfg_w[0];
			`MDR_R_REA_R:  next_rec = rea_w[0];
			`MDR_R_REA_S:  next_rec = rea_w[1];
			`MDR_R_REA_T:  next_rec = rea_w[2];
			`MDR_R_CFG1:   next_rec = cfg_w[1];
			`MDR_R_FUN_R:  next_rec = fun_w[0];
			`MDR_R_FUN_S:  next_rec = fun_w[1];
			`MDR_R_FUN_T:  next_rec = fun_w[2];
			`MDR_R_CFG2:   next_rec = cfg_w[2];
			`MDR_R_ACC_R:  next_rec = acc_w[0];
			`MDR_R_ACC_S:  next_rec = acc_w[1];
			`MDR_R_ACC_T:  next_rec = acc_w[2];
			`MDR_R_CFG3:   next_rec = cfg_w[3];
			default:       next_rec = {`MDR_DATA_W{1'b0}};
		endcase
	end
	// per-bit odd parity over the seven nibbles
	integer n;
	always @* begin
		nib_x = {`MDR_NIB_W{1'b0}};
		for (n = 0; n < `MDR_NIBS; n = n + 1) begin
			nib_x = nib_x ^ next_rec[n*`MDR_NIB_W +: `MDR_NIB_W];
		end
	end
	// group seed keeps the host fold at all ones
	assign parity = ~nib_x ^ {1'b0, asm_idx[4:2]};
	// ************************************************************
	// record assembler and buffer
	// ************************************************************
	wire                    fifo_in_ready;
	wire                    fifo_out_valid;
	wire [`MDR_WORD_W-1:0]  fifo_out_data;
	wire                    fifo_out_ready;
	wire                    fifo_flush;
	reg                     loaded;
	reg                     frame;
	assign fifo_flush     = cs_start | cs_end;
	assign fifo_out_ready = frame & ~loaded;
	// whole record captured in one cycle
	mdr_fifo #(
		.WIDTH (`MDR_WORD_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clock_i     (clock_i),
		.reset_n_i   (rst_n),
		.flush_i     (fifo_flush),
		.in_valid_i  (asm_run),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({parity, next_rec}),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data)
	);
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			asm_idx         <= 5'h00;
			asm_run         <= 1'b0;
			frame           <= 1'b0;
			group_pointer_o <= 3'h0;
		end else begin
			if (cs_start) begin
				// frame starts at the precharged group
				asm_idx <= {group_pointer_o, 2'h0};
				asm_run <= 1'b1;
				frame   <= 1'b1;
			end else if (cs_end) begin
				asm_run         <= 1'b0;
				frame           <= 1'b0;
				group_pointer_o <= 3'h0;
			end else if (asm_run && fifo_in_ready) begin
				// wrap after the last of the seven groups
				asm_idx <= (asm_idx == `MDR_REC_LAST) ? 5'h00 : asm_idx + 5'h01;
			end
			if (pre_rise && !frame && !cs_start) begin
				group_pointer_o <= (group_pointer_o == `MDR_GRP_LAST) ? 3'h0
					: group_pointer_o + 3'h1;
			end
		end
	end
	// ************************************************************
	// serial shifter
	// ************************************************************
	reg  [`MDR_WORD_W-1:0]  shreg;
	reg  [4:0]              bitcnt;
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			shreg    <= {`MDR_WORD_W{1'b0}};
			bitcnt   <= 5'h00;
			loaded   <= 1'b0;
			sdo_o    <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			sdo_oe_o <= frame;
			if (!frame) begin
				loaded <= 1'b0;
				sdo_o  <= 1'b0;
			end else if (!loaded) begin
				if (fifo_out_valid) begin
					shreg  <= fifo_out_data;
					sdo_o  <= fifo_out_data[`MDR_WORD_W-1];
					bitcnt <= `MDR_BIT_LAST;
					loaded <= 1'b1;
				end
			end else if (sclk_fall) begin
				// msb first; data changes on falling edges of the link clock
				if (bitcnt == 5'h00) begin
					loaded <= 1'b0;
				end else begin
					shreg  <= {shreg[`MDR_WORD_W-2:0], 1'b0};
					sdo_o  <= shreg[`MDR_WORD_W-2];
					bitcnt <= bitcnt - 5'h01;
				end
			end
		end
	end
endmodule // mdr_readout
`default_nettype wire

// File: test/mdr_readout_checker.sv
// assertions on the pins of the record readout
`timescale 1ns/100ps
`default_nettype none
module mdr_readout_checker (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       reset_n_i,
	// serial pins
	input wire logic       scs_n_i,
	input wire logic       precharge_i,
	input wire logic       sdo_oe_o,
	input wire logic [2:0] group_pointer_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	property p_oe_rise; $fell(scs_n_i) |-> ##[4:12] sdo_oe_o; endproperty
	property p_oe_hold; (!scs_n_i) [*8] |-> sdo_oe_o; endproperty
	property p_oe_idle; scs_n_i [*8] |-> !sdo_oe_o; endproperty
	property p_oe_drop; $rose(scs_n_i) |-> ##[1:8] !sdo_oe_o; endproperty
	property p_ptr_range; group_pointer_o <= 3'h6; endproperty
	property p_ptr_step;
		$changed(group_pointer_o) |->
			(group_pointer_o == 3'h0) || (group_pointer_o == $past(group_pointer_o) + 3'h1);
	endproperty
	property p_ptr_frame; (!scs_n_i) [*8] |-> $stable(group_pointer_o); endproperty
	property p_ptr_end; $rose(scs_n_i) |-> ##[3:10] (group_pointer_o == 3'h0); endproperty
	// five cycles of pin filter and edge detect; the wrap from six is checked too
	property p_prech_step;
		($rose(precharge_i) && scs_n_i && !sdo_oe_o) |->
			##5 (group_pointer_o == (($past(group_pointer_o, 5) == 3'h6) ? 3'h0
				: $past(group_pointer_o, 5) + 3'h1));
	endproperty

	a_oe_rise: assert property (p_oe_rise) else $error("drive enable late");
	a_oe_hold: assert property (p_oe_hold) else $error("drive enable lost");
	a_oe_idle: assert property (p_oe_idle) else $error("drive outside frame");
	a_oe_drop: assert property (p_oe_drop) else $error("drive kept after frame");
	a_ptr_range: assert property (p_ptr_range) else $error("pointer past six");
	a_ptr_step: assert property (p_ptr_step) else $error("pointer jumped");
	a_ptr_frame: assert property (p_ptr_frame) else $error("pointer moved in frame");
	a_ptr_end: assert property (p_ptr_end) else $error("pointer kept after frame");
	a_prech_step: assert property (p_prech_step) else $error("precharge not counted");

	c_prech: cover property ($rose(precharge_i) && scs_n_i);
	c_wrap: cover property (group_pointer_o == 3'h6 ##[1:20] group_pointer_o == 3'h0);
	c_frame: cover property ($fell(sdo_oe_o));
endmodule // mdr_readout_checker

bind mdr_readout mdr_readout_checker i_chk (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .scs_n_i(scs_n_i),
	.precharge_i(precharge_i), .sdo_oe_o(sdo_oe_o), .group_pointer_o(group_pointer_o)
);
`default_nettype wire

// File: test/mdr_host_model.sv
// behavioural serial host reading records and sending precharge
`timescale 1ns/100ps
`default_nettype none
module mdr_host_model (
	// bench clock pacing the host
	input  wire logic clock_i,
	// serial pins toward the device
	output var logic sclk_o,
	output var logic scs_n_o,
	output var logic precharge_o,
	input  wire logic sdo_i
);
	logic [31:0] words [0:31];

	initial begin
		sclk_o = 1'b0;
		scs_n_o = 1'b1;
		precharge_o = 1'b0;
	end

	task automatic precharge_pulse(input int n);
		repeat (n) begin
			@(posedge clock_i);
			precharge_o <= 1'b1;
			repeat (4) @(posedge clock_i);
			precharge_o <= 1'b0;
			repeat (3) @(posedge clock_i);
		end
	endtask

	// fixed order, host picks count
	// link clock idles low, 800 ns period; sample late in the high phase
	task automatic read_frame(input int n);
		@(posedge clock_i);
		scs_n_o <= 1'b0;
		repeat (16) @(posedge clock_i);
		for (int k = 0; k < n; k++) begin
			for (int b = 31; b >= 0; b--) begin
				sclk_o <= 1'b1;
				repeat (3) @(posedge clock_i);
				@(negedge clock_i);
				words[k][b] = sdo_i;
				@(posedge clock_i);
				sclk_o <= 1'b0;
				repeat (4) @(posedge clock_i);
			end
		end
		scs_n_o <= 1'b1;
		repeat (10) @(posedge clock_i);
	endtask
endmodule // mdr_host_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the record readout
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic          clock_i;
	logic          reset_n_i;
	logic [1055:0] pat;
	logic [5:0]    ctl;
	wire logic     sclk;
	wire logic     scs_n;
	wire logic     precharge;
	wire logic     sdo;
	wire logic     sdo_oe;
	wire logic [2:0] gptr;
	int            n_fail = 0;
	int            tests_run = 0;
	int            cycles = 0;

	mdr_host_model i_host (
		.clock_i(clock_i), .sclk_o(sclk), .scs_n_o(scs_n), .precharge_o(precharge), .sdo_i(sdo)
	);

	mdr_readout i_dut (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .scs_n_i(scs_n),
		.precharge_i(precharge), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .group_pointer_o(gptr),
		.tp_active_i(pat[0 +: 20]), .tp_reactive_i(pat[20 +: 20]),
		.tp_fundamental_i(pat[40 +: 20]), .tp_status_i(pat[60 +: 12]),
		.test_mode_signals_i(pat[72 +: 4]), .bank_i(pat[1037]), .pump_i(pat[1036]),
		.test_signal_zero_i(pat[1035]), .test_signal_one_i(pat[1034]),
		.test_signal_two_i(pat[1033]), .config_source_i(ctl[0]), .write_enable_i(pat[1038]),
		.period_i(pat[76 +: 36]), .phase_present_i(ctl[5:3]),
		.neutral_dc_offset_i(pat[112 +: 16]), .hall_sensor_input_dc_i(pat[128 +: 16]),
		.neutral_channel_hall_select_i(ctl[1]), .no_neutral_mode_i(ctl[2]),
		.volt_mom_i(pat[144 +: 36]), .line_volt_mom_i(pat[180 +: 36]),
		.curr_mom_i(pat[216 +: 48]), .sum_curr_rms_i(pat[264 +: 12]),
		.neutral_curr_mom_i(pat[276 +: 16]), .volt_rms_i(pat[292 +: 36]),
		.line_volt_rms_i(pat[328 +: 36]), .curr_rms_i(pat[364 +: 48]),
		.neutral_voltage_input_rms_i(pat[412 +: 12]), .hall_sensor_input_rms_i(pat[424 +: 12]),
		.neutral_curr_rms_i(pat[436 +: 16]), .phase_active_i(pat[452 +: 60]),
		.phase_reactive_i(pat[512 +: 60]), .phase_fund_reactive_i(pat[572 +: 60]),
		.phase_fundamental_i(pat[632 +: 60]), .phase_status_i(pat[692 +: 24]),
		.active_no_load_flag_i(pat[800 +: 3]), .reactive_no_load_flag_i(pat[803 +: 3]),
		.fund_no_load_flag_i(pat[806 +: 3]), .single_wire_meter_mode_acc_i(pat[716 +: 60]),
		.phase_delay_i(pat[776 +: 24]), .config_shadow_i(pat[809 +: 112]),
		.config_otp_i(pat[921 +: 112])
	);

	// ********************************
	// expected records and comparison
	// ********************************
	function automatic logic [27:0] exp_rec(input int i);
		int p;
		logic [111:0] cfg;
		logic [11:0] um;
		logic [11:0] ur;
		p = i % 4;
		cfg = ctl[0] ? pat[809 +: 112] : pat[921 +: 112];
		um = ctl[2] ? pat[180 + 12 * p +: 12] : pat[144 + 12 * p +: 12];
		ur = ctl[2] ? pat[328 + 12 * p +: 12] : pat[292 + 12 * p +: 12];
		if (p == 3 && i >= 12)
			return cfg[28 * (i / 4 - 3) +: 28];
		case (i / 4)
		0: case (p)
			0: return {pat[0 +: 20], pat[60 +: 8]};
			1: return {pat[20 +: 20], pat[68 +: 4], pat[72 +: 4]};
			2: return {pat[40 +: 20], pat[1037:1033], ctl[0], pat[1038], 1'b0};
			default: begin
				um = ctl[3] ? pat[76 +: 12] : (ctl[4] ? pat[88 +: 12] : pat[100 +: 12]);
				return {um, ctl[1] ? pat[128 +: 16] : pat[112 +: 16]};
			end
		endcase
		1: return (p < 3) ? {um, pat[216 + 16 * p +: 16]} : {pat[264 +: 12], pat[276 +: 16]};
		2: return (p < 3) ? {ur, pat[364 + 16 * p +: 16]}
			: {ctl[1] ? pat[424 +: 12] : pat[412 +: 12], pat[436 +: 16]};
		3: return {pat[452 + 20 * p +: 20], pat[693 + 8 * p +: 7], pat[800 + p]};
		4: return {cfg[42] ? pat[572 + 20 * p +: 20] : pat[512 + 20 * p +: 20],
			pat[693 + 8 * p +: 7], pat[803 + p]};
		5: return {pat[632 + 20 * p +: 20], pat[693 + 8 * p +: 7], pat[806 + p]};
		default: return {pat[716 + 20 * p +: 20], pat[776 + 8 * p +: 8]};
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		tests_run++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic check_frame(input int start, input int n);
		int idx;
		logic [31:0] w;
		logic [31:0] d;
		logic [31:0] e;
		logic [7:0] x;
		i_host.read_frame(n);
		for (int k = 0; k < n; k++) begin
			idx = (start * 4 + k) % 28;
			w = i_host.words[k];
			d = {4'h0, w[27:0]};
			e = {4'h0, exp_rec(idx)};
			if (idx < 8)
				chk(d, e, "record data");
			else if (idx < 16)
				chk(d, e, "record data");
			else
				chk(d, e, "record data");
			if (idx == 3)
				chk(d >> 16 << 6, e >> 16 << 6, "period in clocks");
			x = w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0] ^ 8'(idx / 4);
			chk({28'h0, x[7:4] ^ x[3:0]}, 32'h0000000f, "parity fold");
		end
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset;
		chk({27'h0, sdo, sdo_oe, gptr}, 32'h0, "reset outputs");
	endtask

	task automatic t_all_records;
		@(posedge clock_i);
		pat <= {33{32'h12345678}};
		ctl <= 6'b001001;
		repeat (2) @(posedge clock_i);
		check_frame(0, 28);
	endtask

	// no neutral, hall channel, cells as source, period from the second phase
	task automatic t_alt_modes;
		@(posedge clock_i);
		pat <= {33{32'h9ab4defa}};
		ctl <= 6'b010110;
		repeat (2) @(posedge clock_i);
		check_frame(0, 28);
	endtask

	task automatic t_precharge;
		@(posedge clock_i);
		ctl <= 6'b100001;
		i_host.precharge_pulse(3);
		chk({29'h0, gptr}, 32'h3, "pointer after three");
		check_frame(3, 5);
		chk({29'h0, gptr}, 32'h0, "pointer after frame");
		i_host.precharge_pulse(7);
		chk({29'h0, gptr}, 32'h0, "pointer wrap");
		check_frame(0, 4);
		i_host.precharge_pulse(6);
		chk({29'h0, gptr}, 32'h6, "pointer at six");
		check_frame(6, 5);
	endtask

	task automatic print_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	// hang guard, well above the expected run of about 18200 cycles
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		reset_n_i = 1'b0;
		pat = {33{32'h12345678}};
		ctl = 6'b001001;
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		t_reset();
		t_all_records();
		t_alt_modes();
		t_precharge();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
